// ### rtl/mfid_pkg.sv
// Constants, codes and helper functions for the multi-function input decoder
//
// Behaviour
// - Each terminal has code 0-74 or 100-174
// - Hundreds digit one inverts the terminal sense
// - Reset codes 0,1,23,39,5,6,9 for terminals
// - Codes 0-4: fwd, rev, 3-wire, local, source
// - Codes 5-15: speed bits, jog, up/down, jogs
// - Codes 16-21 ramp, hold, baseblock; 20,22 reserved
// - Codes 23-38 faults, 39 reset, 40 overheat
// - Codes 41-61 analog, comms, PID, timer, offsets
// - 63,65,69,74 valid; other 62-73 reserved
// - 3-wire code on 3-7 makes 1/2 run/stop
// - Run starts after run held over 2 ms
// - Stop opening stops at once, no filter
// - Direction open forward, closed reverse
// - Power-up run ignored: no run, protect, flash
// - Power-up run accepted when acceptance set
// - 3-wire wiring, 2-wire codes: power-up reverse run
// - Local when closed; no switching while running
// - Unpaired up or down flags selection error
// - Both jogs for 500 ms: alarm, ramp stop
package mfid_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ      = 200;
   localparam int RUN_MIN_US   = 2000;
   localparam int RUN_MIN_CYC  = CLK_MHZ * RUN_MIN_US;
   localparam int JOG_BOTH_MS  = 500;
   localparam int JOG_BOTH_CYC = JOG_BOTH_MS * 1000 * CLK_MHZ;
   localparam int LED_HALF_MS  = 250;
   localparam int LED_HALF_CYC = LED_HALF_MS * 1000 * CLK_MHZ;
   localparam int SETTLE_CYC   = 4;

   // ------------------------------------------------------------------
   // Terminals and codes
   // ------------------------------------------------------------------
   localparam int NUM_TERM = 7;
   localparam int CODE_W   = 8;
   localparam int NUM_FN   = 75;
   localparam logic [7:0] CODE_MAX     = 8'h4a;
   localparam logic [7:0] CODE_INV     = 8'h64;
   localparam logic [7:0] CODE_INV_MAX = 8'hae;
   localparam logic [7:0] DEF_CODE [NUM_TERM] = '{8'h00, 8'h01, 8'h17, 8'h27, 8'h05, 8'h06, 8'h09};

   localparam int FN_FWD    = 0;
   localparam int FN_REV    = 1;
   localparam int FN_3WIRE  = 2;
   localparam int FN_LOCAL  = 3;
   localparam int FN_SRC2   = 4;
   localparam int FN_UP     = 10;
   localparam int FN_DOWN   = 11;
   localparam int FN_UP2    = 12;
   localparam int FN_DOWN2  = 13;
   localparam int FN_FORWARD_JOG   = 14;
   localparam int FN_REVERSE_JOG   = 15;
   localparam int FN_PULSE  = 74;
   localparam int TERM_RUN  = 0;
   localparam int TERM_STOP = 1;
   localparam int TERM_DIR0 = 2;
   localparam int TERM_PULSE = 6;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CODE0  = 8'h00;
   localparam logic [7:0] ADDR_CODE6  = 8'h18;
   localparam logic [7:0] ADDR_CTRL   = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_FUNC0  = 8'h24;
   localparam logic [7:0] ADDR_FUNC1  = 8'h28;
   localparam logic [7:0] ADDR_FUNC2  = 8'h2c;
   localparam logic [7:0] ADDR_PINS   = 8'h30;
   localparam int CTRL_ACCEPT  = 0;
   localparam int ST_RUN       = 0;
   localparam int ST_REVERSE   = 1;
   localparam int ST_3WIRE     = 2;
   localparam int ST_PROTECT   = 3;
   localparam int ST_SEL_ERR   = 4;
   localparam int ST_JOG_ALARM = 5;
   localparam int ST_LOCAL     = 6;
   localparam int ST_SRC2      = 7;
   localparam int ST_PENDING   = 8;

   typedef enum logic [1:0] {
      MFID_STOP = 2'b01,
      MFID_RUN  = 2'b10
   } mfid_run_state_t;

   // ------------------------------------------------------------------
   // Code helpers
   // ------------------------------------------------------------------
   function automatic logic code_ok(input logic [7:0] c);
      return (c <= CODE_MAX) || (c >= CODE_INV && c <= CODE_INV_MAX);
   endfunction

   function automatic logic code_inv(input logic [7:0] c);
      return c >= CODE_INV;
   endfunction

   function automatic logic [6:0] code_base(input logic [7:0] c);
      return (c >= CODE_INV) ? 7'(c - CODE_INV) : 7'(c);
   endfunction

   function automatic logic fn_reserved(input logic [6:0] b);
      case (b)
         7'h14, 7'h16, 7'h2a, 7'h2b, 7'h2c, 7'h33, 7'h38, 7'h3a, 7'h3b,
         7'h3e, 7'h40, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h48, 7'h49: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

endpackage

// ### rtl/mfid_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module mfid_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] next_level;

   // A bit moves only when the second and third stages agree
   always_comb begin
      next_level = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & o_level);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1      <= '0;
         s2      <= '0;
         s3      <= '0;
         o_level <= '0;
      end else begin
         s1      <= i_async;
         s2      <= s1;
         s3      <= s2;
         o_level <= next_level;
      end
   end

endmodule

// ### rtl/mfid_timer.sv
// Saturating hold timer: done once the input has stayed high more than LIMIT cycles
`timescale 1ns/1ps
module mfid_timer #(
   parameter int LIMIT = 16
) (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_hold,
   output logic      o_done
);

   localparam int W = $clog2(LIMIT + 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;

   always_comb begin
      if (!i_hold) begin
         next_count = '0;
      end else if (count != W'(LIMIT)) begin
         next_count = count + W'(1);
      end else begin
         next_count = count;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign o_done = i_hold && (count == W'(LIMIT));

endmodule

// ### rtl/mfid_top.sv
// Multi-function input decoder: APB code registers, terminal decode, run control
`timescale 1ns/1ps
module mfid_top #(
   parameter int RUN_MIN_CYC  = mfid_pkg::RUN_MIN_CYC,
   parameter int JOG_BOTH_CYC = mfid_pkg::JOG_BOTH_CYC,
   parameter int LED_HALF_CYC = mfid_pkg::LED_HALF_CYC
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RESETN,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic [6:0]  I_TERM,
   output logic      [74:0] O_FUNC,
   output logic             O_RUN,
   output logic             O_REVERSE,
   output logic             O_THREE_WIRE,
   output logic             O_PROTECT,
   output logic             O_LED,
   output logic             O_LOCAL,
   output logic             O_SRC2,
   output logic             O_SEL_ERR,
   output logic             O_JOG_ALARM
);

   localparam int NT = mfid_pkg::NUM_TERM;
   localparam int NF = mfid_pkg::NUM_FN;
   localparam int LW = $clog2(LED_HALF_CYC + 1);
   localparam int SW = $clog2(mfid_pkg::SETTLE_CYC + 2);

   // ------------------------------------------------------------------
   // Terminal synchronisers
   // ------------------------------------------------------------------
   logic [NT-1:0] lvl;

   mfid_sync #(.WIDTH(NT)) u_sync (
      .i_clk    (I_CLK),
      .i_resetn (I_RESETN),
      .i_async  (I_TERM),
      .o_level  (lvl)
   );

   // ------------------------------------------------------------------
   // Code registers and APB slave
   // ------------------------------------------------------------------
   logic [7:0]  code      [NT];
   logic [7:0]  next_code [NT];
   logic        accept;
   logic        next_accept;
   logic        next_pready;
   logic        next_pslverr;
   logic [31:0] next_prdata;
   logic        setup;
   logic        access;
   logic        addr_is_code;
   logic [2:0]  code_idx;
   logic [31:0] status_word;

   assign setup        = I_PSEL && !I_PENABLE;
   assign access       = I_PSEL && I_PENABLE && O_PREADY;
   assign addr_is_code = (I_PADDR <= mfid_pkg::ADDR_CODE6) && (I_PADDR[1:0] == 2'b00);
   assign code_idx     = I_PADDR[4:2];

   // One wait-free access cycle: ready and read data are prepared in setup
   always_comb begin
      next_pready  = setup;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      next_accept  = accept;
      for (int t = 0; t < NT; t++) begin
         next_code[t] = code[t];
      end
      if (setup) begin
         if (addr_is_code) begin
            next_prdata = {24'h00_0000, code[code_idx]};
            // Out-of-range codes are refused and the old code kept
            if (I_PWRITE && (!mfid_pkg::code_ok(I_PWDATA[7:0]) || I_PWDATA[31:8] != 24'h00_0000)) begin
               next_pslverr = 1'b1;
            end
         end else begin
            unique case (I_PADDR)
               mfid_pkg::ADDR_CTRL:   next_prdata = {31'h0000_0000, accept};
               mfid_pkg::ADDR_STATUS: next_prdata = status_word;
               mfid_pkg::ADDR_FUNC0:  next_prdata = O_FUNC[31:0];
               mfid_pkg::ADDR_FUNC1:  next_prdata = O_FUNC[63:32];
               mfid_pkg::ADDR_FUNC2:  next_prdata = {21'h00_0000, O_FUNC[74:64]};
               mfid_pkg::ADDR_PINS:   next_prdata = {25'h000_0000, lvl};
               default:               next_pslverr = 1'b1;
            endcase
         end
      end
      if (access && I_PWRITE && !O_PSLVERR) begin
         if (addr_is_code) begin
            next_code[code_idx] = I_PWDATA[7:0];
         end else if (I_PADDR == mfid_pkg::ADDR_CTRL) begin
            next_accept = I_PWDATA[mfid_pkg::CTRL_ACCEPT];
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         for (int t = 0; t < NT; t++) begin
            code[t] <= mfid_pkg::DEF_CODE[t];
         end
         accept    <= 1'b0;
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
      end else begin
         for (int t = 0; t < NT; t++) begin
            code[t] <= next_code[t];
         end
         accept    <= next_accept;
         O_PREADY  <= next_pready;
         O_PSLVERR <= next_pslverr;
         O_PRDATA  <= next_prdata;
      end
   end

   // ------------------------------------------------------------------
   // Function decode
   // ------------------------------------------------------------------
   logic [NF-1:0] fn;
   logic [NF-1:0] assigned;
   logic          three_wire;
   logic          dir_closed;

   always_comb begin
      logic [6:0] b;
      logic       act;
      logic       usable;
      b          = 7'h00;
      act        = 1'b0;
      usable     = 1'b0;
      fn         = '0;
      assigned   = '0;
      three_wire = 1'b0;
      dir_closed = 1'b0;
      for (int t = 0; t < NT; t++) begin
         b      = mfid_pkg::code_base(code[t]);
         act    = lvl[t] ^ mfid_pkg::code_inv(code[t]);
         usable = mfid_pkg::code_ok(code[t]) && !mfid_pkg::fn_reserved(b);
         // Pulse input is only meaningful on the last terminal
         if (b == 7'(mfid_pkg::FN_PULSE) && t != mfid_pkg::TERM_PULSE) begin
            usable = 1'b0;
         end
         if (usable) begin
            fn[b]       = fn[b] | act;
            assigned[b] = 1'b1;
            if (b == 7'(mfid_pkg::FN_3WIRE) && t >= mfid_pkg::TERM_DIR0) begin
               three_wire = 1'b1;
               dir_closed = dir_closed | act;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------------
   logic run_held;
   logic jog_both;

   // Done in the cycle after the minimum, so the press is strictly longer
   mfid_timer #(.LIMIT(RUN_MIN_CYC)) u_run_timer (
      .i_clk    (I_CLK),
      .i_resetn (I_RESETN),
      .i_hold   (three_wire && lvl[mfid_pkg::TERM_RUN]),
      .o_done   (run_held)
   );

   mfid_timer #(.LIMIT(JOG_BOTH_CYC)) u_jog_timer (
      .i_clk    (I_CLK),
      .i_resetn (I_RESETN),
      .i_hold   (fn[mfid_pkg::FN_FORWARD_JOG] && fn[mfid_pkg::FN_REVERSE_JOG]),
      .o_done   (jog_both)
   );

   // ------------------------------------------------------------------
   // Run control and power-up check
   // ------------------------------------------------------------------
   mfid_pkg::mfid_run_state_t state;
   mfid_pkg::mfid_run_state_t next_state;
   logic [SW-1:0] settle;
   logic [SW-1:0] next_settle;
   logic          pending;
   logic          next_pending;
   logic          run_cmd;
   logic          rev_cmd;
   logic          stop_ok;
   logic          allow;
   logic          start;
   logic          stop;
   logic          next_reverse;
   logic          next_local;
   logic          next_src2;
   logic          next_jog_alarm;

   always_comb begin
      stop_ok = lvl[mfid_pkg::TERM_STOP];
      if (three_wire) begin
         run_cmd = lvl[mfid_pkg::TERM_RUN] && stop_ok;
         rev_cmd = dir_closed;
      end else begin
         // Both two-wire commands at once is treated as stop
         run_cmd = fn[mfid_pkg::FN_FWD] ^ fn[mfid_pkg::FN_REV];
         rev_cmd = fn[mfid_pkg::FN_REV];
      end
      next_settle  = settle;
      next_pending = pending;
      if (settle != SW'(mfid_pkg::SETTLE_CYC + 1)) begin
         next_settle = settle + SW'(1);
         // A command seen as the inputs first settle counts as a power-up run
         if (settle == SW'(mfid_pkg::SETTLE_CYC)) begin
            next_pending = run_cmd;
         end
      end else if (!run_cmd) begin
         next_pending = 1'b0;
      end
      allow = !pending || accept;
      next_jog_alarm = jog_both || (O_JOG_ALARM && fn[mfid_pkg::FN_FORWARD_JOG] && fn[mfid_pkg::FN_REVERSE_JOG]);
      if (three_wire) begin
         start = run_held && stop_ok && allow;
         stop  = !stop_ok || !allow;
      end else begin
         start = run_cmd && allow;
         stop  = !run_cmd || !allow;
      end
      start = start && !O_JOG_ALARM && (settle == SW'(mfid_pkg::SETTLE_CYC + 1));
      stop  = stop || O_JOG_ALARM;
      next_state = state;
      unique case (state)
         mfid_pkg::MFID_STOP: if (start) next_state = mfid_pkg::MFID_RUN;
         mfid_pkg::MFID_RUN:  if (stop) next_state = mfid_pkg::MFID_STOP;
         default:             next_state = mfid_pkg::MFID_STOP;
      endcase
      next_reverse = (next_state == mfid_pkg::MFID_RUN) ? rev_cmd : O_REVERSE;
      // Source selection may only change while stopped
      next_local = O_LOCAL;
      next_src2  = O_SRC2;
      if (state == mfid_pkg::MFID_STOP) begin
         next_local = fn[mfid_pkg::FN_LOCAL];
         next_src2  = fn[mfid_pkg::FN_SRC2];
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state       <= mfid_pkg::MFID_STOP;
         settle      <= '0;
         pending     <= 1'b0;
         O_REVERSE   <= 1'b0;
         O_LOCAL     <= 1'b0;
         O_SRC2      <= 1'b0;
         O_JOG_ALARM <= 1'b0;
      end else begin
         state       <= next_state;
         settle      <= next_settle;
         pending     <= next_pending;
         O_REVERSE   <= next_reverse;
         O_LOCAL     <= next_local;
         O_SRC2      <= next_src2;
         O_JOG_ALARM <= next_jog_alarm;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs and protection indicator
   // ------------------------------------------------------------------
   logic [LW-1:0] led_cnt;
   logic [LW-1:0] next_led_cnt;
   logic          led_tick;
   logic          next_led;
   logic          next_protect;
   logic          next_sel_err;

   always_comb begin
      led_tick     = (led_cnt == LW'(LED_HALF_CYC - 1));
      next_led_cnt = led_tick ? '0 : led_cnt + LW'(1);
      next_protect = pending && !accept;
      // Flash only while the protection holds; dark otherwise
      if (!next_protect) begin
         next_led = 1'b0;
      end else if (led_tick) begin
         next_led = !O_LED;
      end else begin
         next_led = O_LED;
      end
      next_sel_err = (assigned[mfid_pkg::FN_UP] ^ assigned[mfid_pkg::FN_DOWN])
                   | (assigned[mfid_pkg::FN_UP2] ^ assigned[mfid_pkg::FN_DOWN2]);
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         led_cnt      <= '0;
         O_LED        <= 1'b0;
         O_PROTECT    <= 1'b0;
         O_SEL_ERR    <= 1'b0;
         O_FUNC       <= '0;
         O_RUN        <= 1'b0;
         O_THREE_WIRE <= 1'b0;
      end else begin
         led_cnt      <= next_led_cnt;
         O_LED        <= next_led;
         O_PROTECT    <= next_protect;
         O_SEL_ERR    <= next_sel_err;
         O_FUNC       <= fn;
         O_RUN        <= (next_state == mfid_pkg::MFID_RUN);
         O_THREE_WIRE <= three_wire;
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[mfid_pkg::ST_RUN]       = O_RUN;
      status_word[mfid_pkg::ST_REVERSE]   = O_REVERSE;
      status_word[mfid_pkg::ST_3WIRE]     = O_THREE_WIRE;
      status_word[mfid_pkg::ST_PROTECT]   = O_PROTECT;
      status_word[mfid_pkg::ST_SEL_ERR]   = O_SEL_ERR;
      status_word[mfid_pkg::ST_JOG_ALARM] = O_JOG_ALARM;
      status_word[mfid_pkg::ST_LOCAL]     = O_LOCAL;
      status_word[mfid_pkg::ST_SRC2]      = O_SRC2;
      status_word[mfid_pkg::ST_PENDING]   = pending;
   end

endmodule

// ### tb/mfid_monitor.sv
// Port checker for the multi-function input decoder
`timescale 1ns/1ps
module mfid_monitor #(
   parameter int RUN_MIN_CYC  = 20,
   parameter int JOG_BOTH_CYC = 50,
   parameter int LED_HALF_CYC = 8
) (
   input wire logic        I_CLK,
   input wire logic        I_RESETN,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic [6:0]  I_TERM,
   input wire logic        O_PREADY,
   input wire logic [74:0] O_FUNC,
   input wire logic        O_RUN,
   input wire logic        O_REVERSE,
   input wire logic        O_THREE_WIRE,
   input wire logic        O_PROTECT,
   input wire logic        O_LED,
   input wire logic        O_JOG_ALARM
);
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   int   hold_cnt;
   int   last_len;
   int   jog_cnt;
   int   led_cnt;
   logic led_q;

   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   // The run button may be released before the start shows, so its last length is kept
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         hold_cnt <= 0;
         last_len <= 0;
         jog_cnt  <= 0;
         led_cnt  <= 0;
         led_q    <= 1'b0;
      end else begin
         hold_cnt <= I_TERM[0] ? hold_cnt + 1 : 0;
         last_len <= I_TERM[0] ? last_len : (hold_cnt > 0 ? hold_cnt : last_len);
         jog_cnt  <= (O_FUNC[14] && O_FUNC[15]) ? jog_cnt + 1 : 0;
         led_cnt  <= (!O_PROTECT || O_LED != led_q) ? 0 : led_cnt + 1;
         led_q    <= O_LED;
      end
   end

   a_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
      else $error("ready not single cycle after setup");
   a_run_min_hold: assert property ($rose(O_RUN) && O_THREE_WIRE |->
      hold_cnt > RUN_MIN_CYC || last_len > RUN_MIN_CYC) else $error("run started on short press");
   a_stop_no_filter: assert property ((O_THREE_WIRE && !I_TERM[1])[*6] |=> !O_RUN)
      else $error("run kept with stop open");
   a_dir_reverse: assert property ((O_RUN && O_THREE_WIRE && O_FUNC[2])[*3] |-> O_REVERSE)
      else $error("direction closed but not reverse");
   a_both_dirs_stop: assert property ((!O_THREE_WIRE && O_FUNC[0] && O_FUNC[1])[*2] |-> !O_RUN)
      else $error("run with both directions");
   a_protect_no_run: assert property (O_PROTECT |-> !O_RUN)
      else $error("run while protected");
   a_led_idle: assert property (!O_PROTECT && !$past(O_PROTECT) |-> !O_LED)
      else $error("indicator on without protection");
   a_led_period: assert property (O_PROTECT && $past(O_PROTECT) |-> led_cnt <= LED_HALF_CYC + 1)
      else $error("indicator not flashing");
   a_jog_alarm_time: assert property ($rose(O_JOG_ALARM) |->
      jog_cnt >= JOG_BOTH_CYC - 3 && jog_cnt <= JOG_BOTH_CYC + 3) else $error("jog alarm timing");
endmodule

bind mfid_top mfid_monitor #(
   .RUN_MIN_CYC(RUN_MIN_CYC), .JOG_BOTH_CYC(JOG_BOTH_CYC), .LED_HALF_CYC(LED_HALF_CYC)
) mfid_monitor_inst (
   .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_TERM(I_TERM),
   .O_PREADY(O_PREADY), .O_FUNC(O_FUNC), .O_RUN(O_RUN), .O_REVERSE(O_REVERSE),
   .O_THREE_WIRE(O_THREE_WIRE), .O_PROTECT(O_PROTECT), .O_LED(O_LED), .O_JOG_ALARM(O_JOG_ALARM)
);

// ### tb/mfid_contacts.sv
// Contact model: steady switch levels plus a timed run push-button
`timescale 1ns/1ps
module mfid_contacts (
   input  wire logic        i_clk,
   input  wire logic [6:0]  i_level,
   input  wire logic        i_push,
   input  wire logic [15:0] i_width,
   output logic      [6:0]  o_term
);
   logic [15:0] left = 16'h0000;

   // Button stays closed for the whole requested width
   always_ff @(posedge i_clk) begin
      if (i_push)
         left <= i_width;
      else if (left != 16'h0000)
         left <= left - 16'h0001;
   end

   assign o_term = i_level | {6'h00, left != 16'h0000};
endmodule

// ### tb/mfid_top_tb.sv
// Self-checking bench for the multi-function input decoder
`timescale 1ns/1ps
module mfid_top_tb;
   localparam int RUN_MIN = 20;
   localparam int JOG_MIN = 50;
   logic        clk = 1'b0;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [6:0]  lvl;
   logic [6:0]  term;
   logic        push;
   logic [15:0] width;
   logic [74:0] func;
   logic        run, rev, three, prot, led, loc, src2, selerr, jalarm;
   logic [7:0]  code [7];
   logic [31:0] rd;
   logic        err;
   int          seed = 27;
   int          bad_count = 0;
   int          check_count = 0;

   always #2.5 clk = ~clk;

   mfid_top #(.RUN_MIN_CYC(RUN_MIN), .JOG_BOTH_CYC(JOG_MIN), .LED_HALF_CYC(8)) mfid_top_inst (
      .I_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_TERM(term), .O_FUNC(func), .O_RUN(run), .O_REVERSE(rev), .O_THREE_WIRE(three),
      .O_PROTECT(prot), .O_LED(led), .O_LOCAL(loc), .O_SRC2(src2), .O_SEL_ERR(selerr),
      .O_JOG_ALARM(jalarm));

   mfid_contacts mfid_contacts_inst (
      .i_clk(clk), .i_level(lvl), .i_push(push), .i_width(width), .o_term(term));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [74:0] seen, input logic [74:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk1(input string what, input logic seen, input logic exp);
      chk(what, {74'h0, seen}, {74'h0, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Setup cycle, then access until ready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         test_done();
      end
   endtask

   function automatic logic rsv(input logic [6:0] b);
      return b inside {7'h14, 7'h16, 7'h2a, 7'h2b, 7'h2c, 7'h33, 7'h38, 7'h3a, 7'h3b, 7'h3e,
                       7'h40, 7'h42, 7'h43, 7'h44, [7'h46:7'h49]};
   endfunction

   function automatic logic [6:0] base(input logic [7:0] c);
      return (c >= 8'h64) ? 7'(c - 8'h64) : 7'(c);
   endfunction

   function automatic logic [74:0] fexp(input logic [6:0] lv);
      logic [74:0] f;
      f = '0;
      for (int t = 0; t < 7; t++)
         if ((lv[t] ^ (code[t] >= 8'h64)) && !rsv(base(code[t])) && (base(code[t]) != 7'h4a || t == 6))
            f[base(code[t])] = 1'b1;
      return f;
   endfunction

   function automatic logic sexp();
      logic [3:0] h;
      h = '0;
      for (int t = 0; t < 7; t++)
         for (int u = 0; u < 4; u++)
            if (base(code[t]) == 7'(u + 10))
               h[u] = 1'b1;
      return (h[0] != h[1]) || (h[2] != h[3]);
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      push = 1'b0;
      width = 16'h0000;
      lvl = 7'h02;
      rstn = 1'b0;
      for (int t = 0; t < 7; t++)
         code[t] = mfid_pkg::DEF_CODE[t];
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      tick(30);
      chk1("protect", prot, 1'b1);
      chk1("run", run, 1'b0);
      apb(1'b1, mfid_pkg::ADDR_CTRL, 32'h1);
      tick(4);
      chk1("run", run, 1'b1);
      chk1("reverse", rev, 1'b1);
      for (int t = 0; t < 7; t++) begin
         apb(1'b0, 8'(4 * t), 32'h0);
         chk("code", {43'h0, rd}, {67'h0, code[t]});
      end
      apb(1'b1, 8'h00, 32'h4b);
      chk1("bad code", err, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {42'h0, err, rd}, {42'h0, 1'b1, 32'h0});
      for (int k = 0; k < 150; k++) begin
         int t;
         t = (k == 2 || k == 77) ? 2 : $unsigned($random(seed)) % 7;
         code[t] = (k < 75) ? 8'(k) : 8'(k + 25);
         apb(1'b1, 8'(4 * t), {24'h0, code[t]});
         chk1("code err", err, 1'b0);
         @(posedge clk);
         lvl <= 7'($random(seed));
         tick(8);
         chk("func", func, fexp(lvl));
         chk1("sel err", selerr, sexp());
      end
      @(posedge clk);
      lvl <= 7'h00;
      for (int t = 0; t < 7; t++) begin
         code[t] = (t >= 2 && t <= 4) ? 8'(t) : 8'h09;
         apb(1'b1, 8'(4 * t), {24'h0, code[t]});
      end
      @(posedge clk);
      lvl <= 7'h0a;
      tick(20);
      chk1("three wire", three, 1'b1);
      chk1("local", loc, 1'b1);
      for (int w = RUN_MIN; w <= RUN_MIN + 2; w++) begin
         @(posedge clk);
         push <= 1'b1;
         width <= 16'(w);
         @(posedge clk);
         push <= 1'b0;
         tick(RUN_MIN + 10);
         chk1("run", run, w > RUN_MIN);
      end
      chk1("reverse", rev, 1'b0);
      @(posedge clk);
      lvl <= 7'h16;
      tick(8);
      chk1("reverse", rev, 1'b1);
      chk1("local", loc, 1'b1);
      chk1("src2", src2, 1'b0);
      @(posedge clk);
      lvl <= 7'h14;
      repeat (3) @(posedge clk);
      lvl <= 7'h16;
      tick(8);
      chk1("run", run, 1'b0);
      chk1("local", loc, 1'b0);
      chk1("src2", src2, 1'b1);
      code[4] = 8'h0e;
      code[5] = 8'h0f;
      apb(1'b1, 8'h10, 32'h0e);
      apb(1'b1, 8'h14, 32'h0f);
      @(posedge clk);
      lvl <= 7'h32;
      tick(JOG_MIN - 10);
      chk1("jog alarm", jalarm, 1'b0);
      tick(20);
      chk1("jog alarm", jalarm, 1'b1);
      @(posedge clk);
      lvl <= 7'h12;
      tick(8);
      chk1("jog alarm", jalarm, 1'b0);
      test_done();
   end
endmodule
